// [verilog/mcb_top.sv]
// module clock control, control hub and local data bus token chain
`timescale 1ns/1ps
`default_nettype none
`include "mcb_consts.svh"

module mcb_top (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // register bus
   input wire mcb_pkg::mcb_axi_req_t axiReq,
   output mcb_pkg::mcb_axi_rsp_t axiRsp,
   // identifier straps
   input wire logic [3:0] chipIdPin,
   // device clock port
   input wire logic dclkIn,
   output logic dclkOut,
   output logic dclkOe,
   output logic dclkRxEn,
   output logic dclkTermEn,
   // master clock port
   input wire logic mclkIn,
   output logic mclkOut,
   output logic mclkOe,
   output logic mclkRxEn,
   // differential control line
   input wire logic ctrlLineIn,
   output logic ctrlLineOut,
   output logic ctrlLineOe,
   // local control port
   input wire logic localCtrlIn,
   output logic localCtrlOut,
   output logic localCtrlOe,
   // control protocol side
   input wire logic ctrlRespBit,
   input wire logic ctrlRespEn,
   input wire logic slaveRdFwd,
   output logic ctrlRxBit,
   // local data bus
   input wire logic [7:0] dataIn,
   output logic [7:0] dataOut,
   output logic [7:0] dataOe,
   // own frame source
   input wire logic [7:0] frmData,
   input wire logic frmValid,
   input wire logic frmLast,
   output logic frmReady,
   // monitored bus bytes
   output logic [7:0] rxByte,
   output logic rxValid,
   output logic [3:0] busSender,
   // serial output settings
   output logic hsEnable,
   output logic [1:0] hsRate,
   output logic moduleRole
);

   mcb_pkg::mcb_state_t st_q;
   mcb_pkg::mcb_state_t st_d;
   logic [15:0] padRaw;
   logic [15:0] fltNext;
   logic rise;
   logic fall;
   logic [3:0] chipId;
   logic masterNow;
   logic ctrlSide;
   logic wrDo;
   logic [31:0] cfgWord;
   logic [31:0] cfgNew;
   logic [31:0] statWord;
   logic [7:0] busByte;

   // ============================================================
   // pad synchronisers
   // pad vector: 0 device_clock_port, 1 mclk, 2 control line, 3 local control,
   // 7:4 identifier straps, 15:8 local data bus
   assign padRaw = {dataIn, chipIdPin, localCtrlIn, ctrlLineIn, mclkIn, dclkIn};

   // a bit only moves once stages two and three agree, so a glitch is dropped
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1) begin : g_flt
         assign fltNext[gi] = (st_q.s2[gi] == st_q.s3[gi]) ? st_q.s3[gi] : st_q.flt[gi];
      end
   endgenerate

   // ============================================================
   // derived levels
   assign rise = st_q.flt[0] & ~st_q.dclkPrev;
   assign fall = ~st_q.flt[0] & st_q.dclkPrev;
   assign chipId = st_q.flt[7:4];
   assign masterNow = (chipId[2:0] == `MCB_MASTER_LOW3);
   // master and point-to-point chips sit on the differential line itself
   assign ctrlSide = st_q.master | st_q.cfg.p2pConfig;
   assign wrDo = st_q.awHeld & st_q.wHeld & ~st_q.bValid;

   assign cfgWord = {20'h00000, st_q.cfg.predId, 3'h0, st_q.cfg.dfltOwner,
                     st_q.cfg.rate, st_q.cfg.p2pConfig, st_q.cfg.sdr};
   assign statWord = {16'h0000, st_q.lastSender, chipId, st_q.grantPend,
                      (st_q.tx != mcb_pkg::TX_IDLE), st_q.busOe, st_q.termEn,
                      st_q.hsEnable, st_q.hsRate, st_q.master};

   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_strb
         assign cfgNew[gi*8 +: 8] = st_q.wStrb[gi] ? st_q.wData[gi*8 +: 8] : cfgWord[gi*8 +: 8];
      end
   endgenerate

   // sdr: whole byte over eight lines; ddr: byte assembled from two nibbles
   assign busByte = st_q.cfg.sdr ? st_q.flt[15:8] : {st_q.flt[11:8], st_q.rxLo};

   // ============================================================
   // next state
   always_comb begin
      st_d = st_q;
      st_d.s1 = padRaw;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      st_d.flt = fltNext;
      st_d.dclkPrev = st_q.flt[0];
      st_d.rxValid = 1'b0;

      // role and pad enables
      st_d.master = masterNow;
      st_d.termEn = masterNow | (chipId == `MCB_TERM_ID_A) | (chipId == `MCB_TERM_ID_B);
      st_d.dclkOut = st_q.flt[1];
      st_d.hsEnable = st_q.cfg.p2pConfig | masterNow;
      st_d.hsRate = st_q.cfg.p2pConfig ? st_q.cfg.rate : `MCB_RATE_400;

      // register write: address and data taken in either order
      if (axiReq.awvalid && !st_q.awHeld) begin
         st_d.awHeld = 1'b1;
         st_d.awAddr = axiReq.awaddr;
      end
      if (axiReq.wvalid && !st_q.wHeld) begin
         st_d.wHeld = 1'b1;
         st_d.wData = axiReq.wdata;
         st_d.wStrb = axiReq.wstrb;
      end
      if (wrDo) begin
         st_d.awHeld = 1'b0;
         st_d.wHeld = 1'b0;
         st_d.bValid = 1'b1;
         st_d.bResp = `MCB_RESP_OK;
         if (st_q.awAddr[7:2] == 6'(`MCB_CFG_OFS >> 2)) begin
            st_d.cfg.sdr = cfgNew[`MCB_CFG_SDR];
            st_d.cfg.p2pConfig = cfgNew[`MCB_CFG_P2P];
            st_d.cfg.rate = cfgNew[`MCB_CFG_RATE_LO +: 2];
            st_d.cfg.dfltOwner = cfgNew[`MCB_CFG_DFLT];
            st_d.cfg.predId = cfgNew[`MCB_CFG_PRED_LO +: 4];
         end else if (st_q.awAddr[7:2] != 6'(`MCB_STAT_OFS >> 2)) begin
            st_d.bResp = `MCB_RESP_ERR;
         end
      end else if (st_q.bValid && axiReq.bready) begin
         st_d.bValid = 1'b0;
      end

      // register read
      if (axiReq.arvalid && !st_q.rValid) begin
         st_d.rValid = 1'b1;
         st_d.rResp = `MCB_RESP_OK;
         if (axiReq.araddr[7:2] == 6'(`MCB_CFG_OFS >> 2)) begin
            st_d.rData = cfgWord;
         end else if (axiReq.araddr[7:2] == 6'(`MCB_STAT_OFS >> 2)) begin
            st_d.rData = statWord;
         end else begin
            st_d.rData = 32'h0000_0000;
            st_d.rResp = `MCB_RESP_ERR;
         end
      end else if (st_q.rValid && axiReq.rready) begin
         st_d.rValid = 1'b0;
      end

      // control line and local control port, moved only on device clock rise
      if (rise) begin
         st_d.ctrlOe = 1'b0;
         st_d.lclOe = 1'b0;
         if (st_q.master) begin
            st_d.lclOut = st_q.flt[2];
            st_d.lclOe = ~slaveRdFwd;
            if (slaveRdFwd) begin
               st_d.ctrlOut = st_q.flt[3];
               st_d.ctrlOe = 1'b1;
            end
         end
         if (ctrlRespEn) begin
            // the controller keeps off the line while a chip answers
            if (ctrlSide) begin
               st_d.ctrlOut = ctrlRespBit;
               st_d.ctrlOe = 1'b1;
            end else begin
               st_d.lclOut = ctrlRespBit;
               st_d.lclOe = 1'b1;
            end
         end
      end

      // bus monitor: ddr low nibble sampled at fall, byte complete at rise
      if (fall) begin
         st_d.rxLo = st_q.flt[11:8];
      end
      if (rise) begin
         st_d.rxByte = busByte;
         st_d.rxValid = 1'b1;
         if (busByte[7:4] == `MCB_HDR_CODE) begin
            st_d.lastSender = busByte[3:0];
         end
         // data bytes must avoid the trailer code; there is no escaping
         if (busByte[7:4] == `MCB_TRL_CODE && busByte[3:0] == st_q.cfg.predId
             && !st_q.cfg.dfltOwner && st_q.tx == mcb_pkg::TX_IDLE) begin
            st_d.grantPend = 1'b1;
         end
      end

      // frame transmitter, one byte per device clock period
      if (rise) begin
         unique case (st_q.tx)
            mcb_pkg::TX_IDLE: begin
               st_d.busOe = st_q.cfg.dfltOwner;
               st_d.txByte = `MCB_IDLE_BYTE;
               if (st_d.grantPend || (st_q.cfg.dfltOwner && frmValid)) begin
                  st_d.grantPend = 1'b0;
                  st_d.busOe = 1'b1;
                  st_d.txByte = {`MCB_HDR_CODE, chipId};
                  st_d.tx = mcb_pkg::TX_HDR;
               end
            end
            mcb_pkg::TX_HDR, mcb_pkg::TX_DATA: begin
               st_d.tx = mcb_pkg::TX_DATA;
               st_d.txByte = `MCB_IDLE_BYTE;
               if (frmValid) begin
                  st_d.txByte = frmData;
                  if (frmLast) begin
                     st_d.tx = mcb_pkg::TX_TRL;
                  end
               end
            end
            mcb_pkg::TX_TRL: begin
               st_d.txByte = {`MCB_TRL_CODE, chipId};
               st_d.tx = mcb_pkg::TX_IDLE;
            end
         endcase
      end
      // the trailer stands one period, then the bus is let go unless the chip is default owner
      if (rise && st_q.tx == mcb_pkg::TX_IDLE && st_q.txByte[7:4] == `MCB_TRL_CODE
          && !st_d.busOe) begin
         st_d.busOe = 1'b0;
      end
   end

   // ============================================================
   // state register
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         st_q <= '0;
         st_q.cfg.p2pConfig <= 1'b1;
         st_q.tx <= mcb_pkg::TX_IDLE;
         st_q.txByte <= `MCB_IDLE_BYTE;
         st_q.hsRate <= `MCB_RATE_1G2;
      end else begin
         st_q <= st_d;
      end
   end

   // ============================================================
   // outputs
   always_comb begin
      axiRsp.awready = ~st_q.awHeld;
      axiRsp.wready = ~st_q.wHeld;
      axiRsp.bvalid = st_q.bValid;
      axiRsp.bresp = st_q.bResp;
      axiRsp.arready = ~st_q.rValid;
      axiRsp.rvalid = st_q.rValid;
      axiRsp.rdata = st_q.rData;
      axiRsp.rresp = st_q.rResp;
   end

   assign dclkRxEn = 1'b1;
   assign dclkOut = st_q.dclkOut;
   assign dclkOe = st_q.master;
   assign dclkTermEn = st_q.termEn;
   assign mclkOut = 1'b0;
   assign mclkOe = 1'b0;
   assign mclkRxEn = st_q.master;
   assign ctrlLineOut = st_q.ctrlOut;
   assign ctrlLineOe = st_q.ctrlOe;
   assign localCtrlOut = st_q.lclOut;
   assign localCtrlOe = st_q.lclOe;
   assign ctrlRxBit = ctrlSide ? st_q.flt[2] : st_q.flt[3];

   // ddr: low nibble while clock high, high nibble while low; top lines idle
   assign dataOut = st_q.cfg.sdr ? st_q.txByte
                    : {4'h0, (st_q.flt[0] ? st_q.txByte[3:0] : st_q.txByte[7:4])};
   assign dataOe = st_q.cfg.sdr ? {8{st_q.busOe}} : {4'h0, {4{st_q.busOe}}};
   assign frmReady = rise & (st_q.tx == mcb_pkg::TX_HDR || st_q.tx == mcb_pkg::TX_DATA);
   assign rxByte = st_q.rxByte;
   assign rxValid = st_q.rxValid;
   assign busSender = st_q.lastSender;
   assign hsEnable = st_q.hsEnable;
   assign hsRate = st_q.hsRate;
   assign moduleRole = st_q.master;

endmodule // mcb_top
`default_nettype wire

// [verilog/mcb_consts.svh]
// constants of the module clock, control hub and local data bus token block
// ============================================================
// Function
// - device clock port receiver is always enabled.
// - all core logic is timed only by edges of the device clock port; code clocks all logic on clk_sys, register bus and pad enables every cycle.
// - identifier low three bits zero makes module master: clock driver, master rx on.
// - master forwards master clock port input out on device clock driver.
// - termination on for master, or slave whose four-bit identifier is 6.
// - termination also on for slave identifier 14; discrepancy kept for review.
// - master clock port driver is never enabled.
// - control line is half-duplex; each bit is synchronous to device clock.
// - chip replies serially on the control line synchronous to its clock.
// - master copies control line to local port and forwards slave read replies.
// - point-to-point serial output defaults 1.2 Gbps; 600 or 400 Mb/s selectable.
// - module master serial output runs 400 Mbps carrying its six slaves' data; code gives 400 only while p2pConfig is clear, else the configured rate.
// - default: four low bus lines double data rate, one byte per clock.
// - option: single data rate on eight lines, one byte per clock.
// - default bus owner drives the local bus while no frame is sent.
// - others hold predecessor identifier and watch frames to track the sender.
// - after predecessor frame completes, send exactly one whole frame.
// - after own frame, release bus drivers and wait for next slot.
// - chain order and default owner set in configuration registers.
`ifndef MCB_CONSTS_SVH
`define MCB_CONSTS_SVH

// ============================================================
// register map
`define MCB_CFG_OFS 8'h00
`define MCB_STAT_OFS 8'h04
`define MCB_CFG_RST 32'h0000_0002
`define MCB_CFG_MASK 32'h0000_0f1f

// ============================================================
// config fields
`define MCB_CFG_SDR 0
`define MCB_CFG_P2P 1
`define MCB_CFG_RATE_LO 2
`define MCB_CFG_DFLT 4
`define MCB_CFG_PRED_LO 8

// ============================================================
// identifiers and rates
`define MCB_MASTER_LOW3 3'h0
`define MCB_TERM_ID_A 4'h6
`define MCB_TERM_ID_B 4'he
`define MCB_RATE_1G2 2'h0
`define MCB_RATE_600 2'h1
`define MCB_RATE_400 2'h2

// ============================================================
// local bus framing and register bus response codes
`define MCB_HDR_CODE 4'ha
`define MCB_TRL_CODE 4'hb
`define MCB_IDLE_BYTE 8'hff
`define MCB_RESP_OK 2'h0
`define MCB_RESP_ERR 2'h2

`endif

// [verilog/mcb_pkg.sv]
// types of the module clock, control hub and local data bus token block
package mcb_pkg;

   // ============================================================
   // bus carriers
   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } mcb_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } mcb_axi_rsp_t;

   // ============================================================
   // frame transmit states
   typedef enum logic [3:0] {
      TX_IDLE = 4'h1,
      TX_HDR = 4'h2,
      TX_DATA = 4'h4,
      TX_TRL = 4'h8
   } mcb_tx_t;

   typedef struct packed {
      logic sdr;
      logic p2pConfig;
      logic [1:0] rate;
      logic dfltOwner;
      logic [3:0] predId;
   } mcb_cfg_t;

   // ============================================================
   // whole block state
   typedef struct packed {
      logic [15:0] s1;
      logic [15:0] s2;
      logic [15:0] s3;
      logic [15:0] flt;
      logic dclkPrev;
      mcb_cfg_t cfg;
      logic awHeld;
      logic [7:0] awAddr;
      logic wHeld;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
      mcb_tx_t tx;
      logic grantPend;
      logic [7:0] txByte;
      logic busOe;
      logic [3:0] rxLo;
      logic [3:0] lastSender;
      logic [7:0] rxByte;
      logic rxValid;
      logic ctrlOut;
      logic ctrlOe;
      logic lclOut;
      logic lclOe;
      logic dclkOut;
      logic master;
      logic termEn;
      logic hsEnable;
      logic [1:0] hsRate;
   } mcb_state_t;

endpackage

// [verification/mcb_top_sva.sv]
// assertion checker for the module clock and token bus block
`timescale 1ns/1ps
`default_nettype none

module mcb_chk (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // register bus
   input wire mcb_pkg::mcb_axi_req_t axiReq,
   input wire mcb_pkg::mcb_axi_rsp_t axiRsp,
   // straps and clock ports
   input wire logic [3:0] chipIdPin,
   input wire logic dclkOe,
   input wire logic dclkRxEn,
   input wire logic dclkTermEn,
   input wire logic mclkOut,
   input wire logic mclkOe,
   input wire logic mclkRxEn,
   input wire logic moduleRole,
   // frame handshakes
   input wire logic rxValid,
   input wire logic frmReady
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   // ==========================================
   // clock pads and role
   property p_rxOn;
      dclkRxEn;
   endproperty
   a_rxOn: assert property (p_rxOn)
      else $error("device clock receiver off");
   property p_mclkOff;
      !mclkOe && !mclkOut;
   endproperty
   a_mclkOff: assert property (p_mclkOff)
      else $error("master clock driver on");
   // straps pass a filter, so only judge after they held still
   property p_role;
      $stable(chipIdPin) [*8] |-> moduleRole == (chipIdPin[2:0] == 3'h0);
   endproperty
   a_role: assert property (p_role)
      else $error("role does not follow identifier");
   property p_roleOut;
      $stable(chipIdPin) [*8] |-> dclkOe == (chipIdPin[2:0] == 3'h0) && mclkRxEn == dclkOe;
   endproperty
   a_roleOut: assert property (p_roleOut)
      else $error("clock pad enables wrong for role");
   property p_term;
      $stable(chipIdPin) [*8] |-> dclkTermEn ==
         (chipIdPin[2:0] == 3'h0 || chipIdPin == 4'h6 || chipIdPin == 4'he);
   endproperty
   a_term: assert property (p_term)
      else $error("termination wrong for identifier");

   // ==========================================
   // register bus and bus handshakes
   property p_rdLat;
      axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid;
   endproperty
   a_rdLat: assert property (p_rdLat)
      else $error("read answer late");
   property p_wrLat;
      axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready
         |=> !axiRsp.bvalid ##1 axiRsp.bvalid;
   endproperty
   a_wrLat: assert property (p_wrLat)
      else $error("write answer timing wrong");
   property p_rxPulse;
      rxValid |=> !rxValid [*3];
   endproperty
   a_rxPulse: assert property (p_rxPulse)
      else $error("monitored byte pulse too long");
   property p_frmPulse;
      frmReady |=> !frmReady;
   endproperty
   a_frmPulse: assert property (p_frmPulse)
      else $error("frame ready not a pulse");
endmodule // mcb_chk

bind mcb_top mcb_chk chk (.clk_sys, .rstn, .axiReq, .axiRsp, .chipIdPin, .dclkOe,
   .dclkRxEn, .dclkTermEn, .mclkOut, .mclkOe, .mclkRxEn, .moduleRole, .rxValid, .frmReady);
`default_nettype wire

// [verification/mcb_peer.sv]
// peer chip model: link clock source and default bus owner
`timescale 1ns/1ps
`default_nettype none

module mcb_peer (
   // link clock
   output logic pclk,
   // bus byte offered while the chip is not driving
   output logic [7:0] pData
);
   // ==========================================
   // free running clock, phase unrelated to clk_sys
   initial begin
      pclk = 1'b0;
      pData = 8'hff;
      #137;
      forever #400 pclk = ~pclk;
   end

   // ==========================================
   // one whole frame, launched on falling edges
   task automatic sendFrame(input logic [3:0] id);
      logic [7:0] f [4];
      f = '{{4'ha, id}, 8'h31, 8'h32, {4'hb, id}};
      foreach (f[i]) begin
         @(negedge pclk);
         pData = f[i];
      end
      @(negedge pclk);
      pData = 8'hff;
   endtask
endmodule // mcb_peer
`default_nettype wire

// [verification/mcb_top_tb.sv]
// self-checking bench for the module clock and token bus block
`timescale 1ns/1ps
`default_nettype none
`include "mcb_consts.svh"

module mcb_top_tb;
   // ==========================================
   // signals
   logic clk_sys, rstn, pclk, dclkIn, ctrlLineIn, ctrlDrv, locDrv;
   mcb_pkg::mcb_axi_req_t axiReq;
   mcb_pkg::mcb_axi_rsp_t axiRsp;
   logic [3:0] chipIdPin, busSender;
   logic dclkOut, dclkOe, dclkRxEn, dclkTermEn, mclkOut, mclkOe, mclkRxEn, moduleRole;
   logic ctrlLineOut, ctrlLineOe, localCtrlOut, ctrlRespBit, ctrlRespEn, slaveRdFwd;
   logic [7:0] dataIn, dataOut, dataOe, pData, frmData, rxByte;
   logic frmValid, frmLast, frmReady, rxValid;
   logic [1:0] hsRate, r;
   logic [1:0] fIdx = 2'd0;
   logic [31:0] d;
   logic [7:0] drv [$];
   logic [7:0] mon [$];
   logic [3:0] ids [5] = '{4'h5, 4'h6, 4'he, 4'h8, 4'h0};
   logic [7:0] exp [8] = '{{`MCB_HDR_CODE, 4'h3}, 8'h31, 8'h32, {`MCB_TRL_CODE, 4'h3},
      {`MCB_HDR_CODE, 4'h5}, 8'h41, 8'h42, {`MCB_TRL_CODE, 4'h5}};
   int err_count = 0;
   int checked = 0;
   int cycles = 0;
   int fwdCnt = 0;
   int n;
   logic m, t;

   mcb_peer p (.pclk, .pData);
   mcb_top dut (.clk_sys, .rstn, .axiReq, .axiRsp, .chipIdPin, .dclkIn, .dclkOut, .dclkOe,
      .dclkRxEn, .dclkTermEn, .mclkIn(pclk), .mclkOut, .mclkOe, .mclkRxEn, .ctrlLineIn,
      .ctrlLineOut, .ctrlLineOe, .localCtrlIn(locDrv), .localCtrlOut, .localCtrlOe(),
      .ctrlRespBit, .ctrlRespEn, .slaveRdFwd, .ctrlRxBit(), .dataIn, .dataOut, .dataOe,
      .frmData, .frmValid, .frmLast, .frmReady, .rxByte, .rxValid, .busSender,
      .hsEnable(), .hsRate, .moduleRole);

   // ==========================================
   // wires and far side
   assign dclkIn = dclkOe ? dclkOut : pclk;
   assign ctrlLineIn = ctrlLineOe ? ctrlLineOut : ctrlDrv;
   assign dataIn = (dataOe != 8'h00) ? dataOut : pData;
   assign frmValid = fIdx != 2'd2;
   assign frmLast = fIdx == 2'd1;
   assign frmData = 8'h41 + {6'h0, fIdx};
   always @(posedge clk_sys) begin
      if (frmValid && frmReady) begin
         fIdx <= fIdx + 2'd1;
      end
      if (rxValid && rxByte != 8'hff) begin
         mon.push_back(rxByte);
      end
   end
   always @(posedge dclkIn) begin
      if (dataOe != 8'h00) begin
         drv.push_back(dataOut);
      end
   end
   always @(posedge dclkOut) fwdCnt++;

   // ==========================================
   // tasks
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic axiWr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      logic aw, w, done;
      aw = 1'b1;
      w = 1'b1;
      done = 1'b0;
      @(posedge clk_sys);
      axiReq.awaddr <= a;
      axiReq.wdata <= v;
      axiReq.wstrb <= 4'hf;
      axiReq.awvalid <= 1'b1;
      axiReq.wvalid <= 1'b1;
      axiReq.bready <= 1'b1;
      while (!done) begin
         @(posedge clk_sys);
         done = !aw && !w && axiRsp.bvalid;
         rs = axiRsp.bresp;
         if (aw && axiRsp.awready) begin
            aw = 1'b0;
            axiReq.awvalid <= 1'b0;
         end
         if (w && axiRsp.wready) begin
            w = 1'b0;
            axiReq.wvalid <= 1'b0;
         end
      end
      axiReq.bready <= 1'b0;
   endtask
   task automatic axiRd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      logic ar, done;
      ar = 1'b1;
      done = 1'b0;
      @(posedge clk_sys);
      axiReq.araddr <= a;
      axiReq.arvalid <= 1'b1;
      axiReq.rready <= 1'b1;
      while (!done) begin
         @(posedge clk_sys);
         if (ar && axiRsp.arready) begin
            ar = 1'b0;
            axiReq.arvalid <= 1'b0;
         end else if (!ar && axiRsp.rvalid) begin
            done = 1'b1;
            v = axiRsp.rdata;
            rs = axiRsp.rresp;
         end
      end
      axiReq.rready <= 1'b0;
   endtask
   task automatic setId(input logic [3:0] i);
      @(posedge clk_sys);
      chipIdPin <= i;
      repeat (12) @(posedge clk_sys);
   endtask
   task automatic dclkWait(input int k);
      repeat (k) @(posedge pclk);
      @(posedge clk_sys);
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ==========================================
   // clock, timeout and test sequence
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // whole run needs under a thousand cycles
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         end_of_test();
      end
   end
   initial begin
      rstn = 1'b0;
      axiReq = '0;
      chipIdPin = 4'h5;
      ctrlDrv = 1'b0;
      locDrv = 1'b0;
      ctrlRespBit = 1'b0;
      ctrlRespEn = 1'b0;
      slaveRdFwd = 1'b0;
      repeat (16) @(posedge clk_sys);
      rstn <= 1'b1;
      axiRd(`MCB_CFG_OFS, d, r);
      chk("cfg reset", `MCB_CFG_RST, d);
      axiWr(`MCB_CFG_OFS, 32'hffff_ffef, r);
      axiRd(`MCB_CFG_OFS, d, r);
      chk("cfg mask", `MCB_CFG_MASK & 32'hffff_ffef, d);
      axiWr(`MCB_STAT_OFS, 32'h0, r);
      chk("stat bresp", 32'(`MCB_RESP_OK), 32'(r));
      axiWr(8'h08, 32'h1, r);
      chk("bad bresp", 32'(`MCB_RESP_ERR), 32'(r));
      axiRd(8'h08, d, r);
      chk("bad rresp", 32'(`MCB_RESP_ERR), 32'(r));
      $display("registers done");
      foreach (ids[i]) begin
         setId(ids[i]);
         m = ids[i][2:0] == `MCB_MASTER_LOW3;
         t = m || ids[i] == `MCB_TERM_ID_A || ids[i] == `MCB_TERM_ID_B;
         chk("pads", 32'({m, m, m, t, 3'b100}), 32'({moduleRole, dclkOe, mclkRxEn,
            dclkTermEn, dclkRxEn, mclkOe, mclkOut}));
         axiRd(`MCB_STAT_OFS, d, r);
         chk("stat id", 32'(ids[i]), 32'(d[11:8]));
      end
      @(posedge pclk);
      n = fwdCnt;
      repeat (16) @(posedge pclk);
      chk("fwd edges", 32'd16, fwdCnt - n);
      $display("roles done");
      for (int k = 0; k < 3; k++) begin
         axiWr(`MCB_CFG_OFS, 32'h3 | (k << 2), r);
         repeat (4) @(posedge clk_sys);
         chk("rate", k, 32'(hsRate));
      end
      axiWr(`MCB_CFG_OFS, 32'h1, r);
      repeat (4) @(posedge clk_sys);
      chk("module rate", 32'(`MCB_RATE_400), 32'(hsRate));
      for (int k = 0; k < 4; k++) begin
         ctrlDrv <= k[0];
         dclkWait(2);
         chk("hub copy", 32'(k[0]), 32'(localCtrlOut));
      end
      for (int k = 0; k < 6; k++) begin
         slaveRdFwd <= k < 2;
         ctrlRespEn <= k == 2 || k == 3;
         ctrlRespBit <= k[0];
         locDrv <= k[0];
         dclkWait(2);
         chk("ctrl drive", (k < 4) ? 32'({1'b1, k[0]}) : 32'h0,
            32'({ctrlLineOe, ctrlLineOut & ctrlLineOe}));
      end
      $display("control done");
      setId(4'h5);
      axiWr(`MCB_CFG_OFS, 32'h0301, r);
      dclkWait(2);
      drv.delete();
      mon.delete();
      p.sendFrame(4'h3);
      dclkWait(10);
      chk("bus bytes", 32'd8, mon.size());
      foreach (mon[i]) chk("bus byte", 32'(exp[i]), 32'(mon[i]));
      chk("own bytes", 32'd4, drv.size());
      foreach (drv[i]) chk("own byte", 32'(exp[i + 4]), 32'(drv[i]));
      chk("release", 32'h0, 32'(dataOe));
      chk("sender", 32'h5, 32'(busSender));
      axiWr(`MCB_CFG_OFS, 32'h0011, r);
      dclkWait(3);
      chk("idle drive", 32'h0000_ffff, 32'({dataOe, dataOut}));
      $display("token chain done");
      end_of_test();
   end
endmodule // mcb_top_tb
`default_nettype wire
